// ===== pcab_core.sv
// Config register access, software access sequence and burst address sequencer
// What this block does
// - Load happens only after read, read, write, write at the top address.
// - Read sequence is the same but fourth operation reads the register.
// - Sequence operations target 1FFFFFh and leave that array word unchanged.
// - Third write data 0000h picks refresh, 0001h bus config, 0002h identification.
// - Fourth operation moves register bits 15:0 in or out.
// - Pin-selected register access stays usable alongside the sequence.
// - Other selector values may overwrite the top array word.
// - Bus configuration resets to 9D1Fh.
// - Bus config reached by select pin with 10b or selector 0001h.
// - All sixteen bus config bits read back exactly as written.
// - Burst length and wrap apply to reads and writes alike.
// - Length field picks 4, 8, 16, 32 words or continuous; continuous default.
// - Continuous bursts step linearly and roll over to address zero.
// - Bit 3 picks wrap within length at zero, sequential at one.
// - Wrap increments only the low bits covering the burst length.
// - Unwrapped fixed bursts cross boundaries and roll over to zero.
// - Select pin high addresses registers, low addresses the array.
// - Pin access bits 19:18: 00 refresh, 10 bus config, 01 identification.
module pcab_core #(
   parameter logic [15:0] IDENT_VALUE = 16'h0A5C // Arbitrary identification value
) (
   input wire logic sys_clk, // Clock
   input wire logic rst_b, // Power-up reset, active low
   input wire logic config_reg_select, // High: register space
   input wire logic op_valid, // Operation offered, sampled on sys_clk
   output logic op_ready, // Operation taken when high
   input wire pcab_pkg::pcab_op_t op_req, // Operation kind, address, data
   output logic arr_valid, // Array request pulse
   output pcab_pkg::pcab_arr_t arr_req, // Array request fields
   input wire logic arr_rvalid, // Array read data returned
   input wire logic [15:0] arr_rdata, // Array read data
   output logic rsp_valid, // Read data available
   input wire logic rsp_ready, // Receiver takes read data
   output logic [15:0] rsp_data, // Read data
   input wire logic burst_start, // Start a burst
   input wire logic [20:0] burst_start_addr, // First word address
   input wire logic burst_adv, // Move to next word
   input wire logic burst_stop, // End burst early
   output logic burst_active, // Burst in progress
   output logic [20:0] burst_addr, // Current burst word address
   output logic [15:0] bus_config, // Bus configuration contents
   output logic [15:0] refresh_config // Refresh configuration contents
);
   import pcab_pkg::*;

   // Elaboration check of the identification value
   if (IDENT_VALUE == 16'h0000) begin : g_bad_ident
      $error("pcab_core: IDENT_VALUE must not be zero");
   end

   // ========================================
   // State
   typedef struct packed {
      logic [15:0] bus_config_reg;
      logic [15:0] refresh_config_reg;
      pcab_seq_t seq;
      logic [15:0] sel;
      logic pend;
      logic arr_valid;
      pcab_arr_t arr;
      logic b_active;
      logic [20:0] b_addr;
      logic [5:0] b_left;
      logic [5:0] b_len;
      logic b_wrap;
   } pcab_state_t;

   pcab_state_t st_reg;
   pcab_state_t st_next;

   // ========================================
   // Helper functions

   // Burst length code to word count, zero meaning continuous
   function automatic logic [5:0] len_words(input logic [2:0] code);
      logic [5:0] w;
      w = WORDS_CONT;
      unique case (code)
         BL_4: w = WORDS_4;
         BL_8: w = WORDS_8;
         BL_16: w = WORDS_16;
         BL_32: w = WORDS_32;
         default: w = WORDS_CONT;
      endcase
      return w;
   endfunction

   // Next word address of a burst
   function automatic logic [20:0] next_addr(input logic [20:0] a, input logic [5:0] len,
                                             input logic wrap);
      logic [20:0] mask;
      logic [20:0] inc;
      mask = {15'h0000, len - 6'h01};
      inc = a + 21'h00_0001;
      if (wrap && (len != WORDS_CONT)) begin
         return (a & ~mask) | (inc & mask);
      end
      return inc;
   endfunction

   // Register contents by software selector
   function automatic logic [15:0] sw_read(input logic [15:0] s, input logic [15:0] b,
                                           input logic [15:0] r);
      logic [15:0] v;
      v = ZERO_WORD;
      if (s == SW_SEL_RCR) v = r;
      else if (s == SW_SEL_BCR) v = b;
      else if (s == SW_SEL_DEVICE_IDENT_REG) v = IDENT_VALUE;
      return v;
   endfunction

   // Register contents by pin selector
   function automatic logic [15:0] pin_read(input logic [1:0] s, input logic [15:0] b,
                                            input logic [15:0] r);
      logic [15:0] v;
      v = ZERO_WORD;
      unique case (s)
         PIN_SEL_RCR: v = r;
         PIN_SEL_BCR: v = b;
         PIN_SEL_DEVICE_IDENT_REG: v = IDENT_VALUE;
         default: v = ZERO_WORD;
      endcase
      return v;
   endfunction

   // Selector names a register
   function automatic logic sel_ok(input logic [15:0] s);
      return (s == SW_SEL_RCR) || (s == SW_SEL_BCR) || (s == SW_SEL_DEVICE_IDENT_REG);
   endfunction

   // ========================================
   // Response path
   logic buf_in_ready;
   logic buf_in_valid;
   logic [15:0] buf_in_data;
   logic take;
   logic at_top;
   logic reg_rd;
   logic [15:0] reg_rd_data;

   // Operations stall while a word is owed or no room for a reply
   assign op_ready = buf_in_ready && !st_reg.pend;
   assign take = op_valid && op_ready;
   assign at_top = (op_req.addr == TOP_ADDR);

   pcab_resp_buf #(
      .WIDTH(DATA_W)
   ) u_resp_buf (
      .clk(sys_clk),
      .rst_b(rst_b),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(buf_in_data),
      .out_valid(rsp_valid),
      .out_ready(rsp_ready),
      .out_data(rsp_data)
   );

   // Register reads: pin path or fourth sequence read
   always_comb begin
      reg_rd = 1'b0;
      reg_rd_data = ZERO_WORD;
      if (take && !op_req.write) begin
         if (config_reg_select) begin
            reg_rd = 1'b1;
            reg_rd_data = pin_read(op_req.addr[SEL_HI:SEL_LO], st_reg.bus_config_reg,
                                   st_reg.refresh_config_reg);
         end else if (st_reg.seq == SEQ_WR3 && at_top && sel_ok(st_reg.sel)) begin
            reg_rd = 1'b1;
            reg_rd_data = sw_read(st_reg.sel, st_reg.bus_config_reg,
                                  st_reg.refresh_config_reg);
         end
      end
   end

   // Register reply or array return into the buffer
   assign buf_in_valid = reg_rd || arr_rvalid;
   assign buf_in_data = reg_rd ? reg_rd_data : arr_rdata;

   // ========================================
   // Next state
   always_comb begin
      st_next = st_reg;
      st_next.arr_valid = 1'b0;
      if (arr_rvalid) begin
         st_next.pend = 1'b0;
      end

      // Operation handling
      if (take) begin
         if (config_reg_select) begin
            // Pin path, sequence state left alone
            if (op_req.write) begin
               unique case (op_req.addr[SEL_HI:SEL_LO])
                  PIN_SEL_BCR: st_next.bus_config_reg = op_req.wdata;
                  PIN_SEL_RCR: st_next.refresh_config_reg = op_req.wdata;
                  default: st_next.bus_config_reg = st_reg.bus_config_reg;
               endcase
            end
         end else begin
            // Array path by default
            st_next.arr_valid = 1'b1;
            st_next.arr.write = op_req.write;
            st_next.arr.addr = op_req.addr;
            st_next.arr.wdata = op_req.wdata;
            st_next.pend = !op_req.write;
            st_next.seq = SEQ_IDLE;
            if (at_top) begin
               unique case (st_reg.seq)
                  SEQ_IDLE: begin
                     if (!op_req.write) st_next.seq = SEQ_RD1;
                  end
                  SEQ_RD1: begin
                     if (!op_req.write) st_next.seq = SEQ_RD2;
                  end
                  SEQ_RD2: begin
                     if (op_req.write) begin
                        st_next.seq = SEQ_WR3;
                        st_next.sel = op_req.wdata;
                        if (sel_ok(op_req.wdata)) begin
                           st_next.arr_valid = 1'b0;
                        end
                        // Bad selector still reaches the array
                        st_next.pend = 1'b0;
                     end
                  end
                  SEQ_WR3: begin
                     if (sel_ok(st_reg.sel)) begin
                        st_next.arr_valid = 1'b0;
                        st_next.pend = 1'b0;
                        if (op_req.write) begin
                           if (st_reg.sel == SW_SEL_BCR) begin
                              st_next.bus_config_reg = op_req.wdata;
                           end else if (st_reg.sel == SW_SEL_RCR) begin
                              st_next.refresh_config_reg = op_req.wdata;
                           end
                        end
                     end
                  end
               endcase
            end
         end
      end

      // Burst sequencing, same for read and write bursts
      if (burst_start) begin
         st_next.b_active = 1'b1;
         st_next.b_addr = burst_start_addr;
         st_next.b_len = len_words(st_reg.bus_config_reg[BL_MSB:BL_LSB]);
         st_next.b_left = len_words(st_reg.bus_config_reg[BL_MSB:BL_LSB]);
         st_next.b_wrap = !st_reg.bus_config_reg[WRAP_BIT];
      end else if (burst_stop) begin
         st_next.b_active = 1'b0;
      end else if (burst_adv && st_reg.b_active) begin
         st_next.b_addr = next_addr(st_reg.b_addr, st_reg.b_len, st_reg.b_wrap);
         if (st_reg.b_len != WORDS_CONT) begin
            st_next.b_left = st_reg.b_left - 6'h01;
            if (st_reg.b_left == 6'h01) begin
               st_next.b_active = 1'b0;
            end
         end
      end
   end

   // ========================================
   // State register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
         st_reg.bus_config_reg <= BCR_RESET;
         st_reg.refresh_config_reg <= RCR_RESET;
         st_reg.seq <= SEQ_IDLE;
         st_reg.arr.addr <= ZERO_ADDR;
      end else begin
         st_reg <= st_next;
      end
   end

   // ========================================
   // Outputs
   assign arr_valid = st_reg.arr_valid;
   assign arr_req = st_reg.arr;
   assign burst_active = st_reg.b_active;
   assign burst_addr = st_reg.b_addr;
   assign bus_config = st_reg.bus_config_reg;
   assign refresh_config = st_reg.refresh_config_reg;
endmodule

// ===== pcab_pkg.sv
// Constants, encodings and carrier types of the config access and burst sequencer
package pcab_pkg;

   // ==============================
   // Widths
   localparam int ADDR_W = 21;
   localparam int DATA_W = 16;
   localparam int CNT_W = 6;

   // ==============================
   // Addresses and register selection
   localparam logic [20:0] TOP_ADDR = 21'h1F_FFFF;
   localparam logic [20:0] ZERO_ADDR = 21'h00_0000;
   localparam int SEL_HI = 19;
   localparam int SEL_LO = 18;
   localparam logic [1:0] PIN_SEL_RCR = 2'h0;
   localparam logic [1:0] PIN_SEL_DEVICE_IDENT_REG = 2'h1;
   localparam logic [1:0] PIN_SEL_BCR = 2'h2;
   localparam logic [15:0] SW_SEL_RCR = 16'h0000;
   localparam logic [15:0] SW_SEL_BCR = 16'h0001;
   localparam logic [15:0] SW_SEL_DEVICE_IDENT_REG = 16'h0002;

   // ==============================
   // Reset values
   localparam logic [15:0] BCR_RESET = 16'h9D1F;
   localparam logic [15:0] RCR_RESET = 16'h0010;
   localparam logic [15:0] ZERO_WORD = 16'h0000;

   // ==============================
   // Bus configuration fields
   localparam int BL_LSB = 0;
   localparam int BL_MSB = 2;
   localparam int WRAP_BIT = 3;
   localparam logic [2:0] BL_4 = 3'h1;
   localparam logic [2:0] BL_8 = 3'h2;
   localparam logic [2:0] BL_16 = 3'h3;
   localparam logic [2:0] BL_32 = 3'h4;
   localparam logic [2:0] BL_CONT = 3'h7;
   localparam logic [5:0] WORDS_4 = 6'h04;
   localparam logic [5:0] WORDS_8 = 6'h08;
   localparam logic [5:0] WORDS_16 = 6'h10;
   localparam logic [5:0] WORDS_32 = 6'h20;
   localparam logic [5:0] WORDS_CONT = 6'h00;

   // ==============================
   // Software sequence states
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_RD1 = 2'b01,
      SEQ_RD2 = 2'b10,
      SEQ_WR3 = 2'b11
   } pcab_seq_t;

   // ==============================
   // Carriers
   typedef struct packed {
      logic write;
      logic [20:0] addr;
      logic [15:0] wdata;
   } pcab_op_t;

   typedef struct packed {
      logic write;
      logic [20:0] addr;
      logic [15:0] wdata;
   } pcab_arr_t;

endpackage

// ===== pcab_resp_buf.sv
// Two-entry response buffer with valid and ready on both sides
module pcab_resp_buf #(
   parameter int WIDTH = 16
) (
   input wire logic clk, // Clock
   input wire logic rst_b, // Async reset, active low
   input wire logic in_valid, // Word offered
   output logic in_ready, // Room for a word
   input wire logic [WIDTH-1:0] in_data, // Word in
   output logic out_valid, // Word held
   input wire logic out_ready, // Receiver takes word
   output logic [WIDTH-1:0] out_data // Oldest word
);
   // Elaboration check of the word width
   if (WIDTH < 1) begin : g_bad_width
      $error("pcab_resp_buf: WIDTH must be positive");
   end

   typedef struct packed {
      logic [1:0] cnt;
      logic [WIDTH-1:0] d0;
      logic [WIDTH-1:0] d1;
   } pcab_buf_st_t;

   pcab_buf_st_t st_reg;
   pcab_buf_st_t st_next;
   logic push;
   logic pop;

   // Handshakes from occupancy
   assign in_ready = (st_reg.cnt != 2'h2);
   assign out_valid = (st_reg.cnt != 2'h0);
   assign out_data = st_reg.d0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Shift on pop, fill first free slot on push
   always_comb begin
      st_next = st_reg;
      if (pop) begin
         st_next.d0 = st_reg.d1;
      end
      unique case ({push, pop})
         2'b10: begin
            if (st_reg.cnt == 2'h0) st_next.d0 = in_data;
            else st_next.d1 = in_data;
            st_next.cnt = st_reg.cnt + 2'h1;
         end
         2'b01: st_next.cnt = st_reg.cnt - 2'h1;
         2'b11: begin
            if (st_reg.cnt == 2'h1) st_next.d0 = in_data;
            else st_next.d1 = in_data;
         end
         2'b00: st_next.cnt = st_reg.cnt;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule

// ===== pcab_mem.sv
// Behavioural model of the memory array behind the core
module pcab_mem (
   input wire logic sys_clk, // Clock
   input wire logic arr_valid, // Request pulse
   input wire pcab_pkg::pcab_arr_t arr_req, // Request fields
   output logic arr_rvalid, // Read word returned
   output logic [15:0] arr_rdata // Read word
);
   timeunit 1ns;
   timeprecision 1ns;
   import pcab_pkg::*;
   logic [15:0] mem [logic [20:0]];
   logic [15:0] hold = 16'h0000;
   int dly = 0;
   logic slow = 1'b0;
   initial begin
      arr_rvalid = 1'b0;
      arr_rdata = 16'h0000;
   end
   // Stores writes, answers reads after one or four cycles in turn
   always @(posedge sys_clk) begin
      arr_rdata <= ~arr_rdata; // Stale data never looks valid
      arr_rvalid <= 1'b0;
      if (dly == 1) begin
         arr_rvalid <= 1'b1;
         arr_rdata <= hold;
      end
      if (dly > 0) dly <= dly - 1;
      if (arr_valid && arr_req.write) mem[arr_req.addr] = arr_req.wdata;
      if (arr_valid && !arr_req.write) begin
         hold <= mem.exists(arr_req.addr) ? mem[arr_req.addr] : arr_req.addr[15:0] ^ 16'h5A5A;
         dly <= slow ? 4 : 1;
         slow <= !slow;
      end
   end
endmodule

// ===== pcab_core_asserts.sv
// Port-level assertions of the config access and burst core
module pcab_core_asserts (
   input wire logic sys_clk, // Clock
   input wire logic rst_b, // Reset, active low
   input wire logic config_reg_select, // Register space
   input wire logic op_valid, // Op offered
   input wire logic op_ready, // Op taken
   input wire pcab_pkg::pcab_op_t op_req, // Op fields
   input wire logic arr_valid, // Array pulse
   input wire pcab_pkg::pcab_arr_t arr_req, // Array fields
   input wire logic rsp_valid, // Word held
   input wire logic rsp_ready, // Word taken
   input wire logic [15:0] rsp_data, // Word
   input wire logic burst_start, // Start
   input wire logic [20:0] burst_start_addr, // First address
   input wire logic burst_adv, // Advance
   input wire logic burst_stop, // Stop
   input wire logic burst_active, // Running
   input wire logic [20:0] burst_addr, // Word address
   input wire logic [15:0] bus_config // Bus config
);
   timeunit 1ns;
   timeprecision 1ns;
   import pcab_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Helper terms
   logic tk;
   logic adv1;
   assign tk = op_valid && op_ready;
   assign adv1 = burst_adv && !burst_start && !burst_stop;
   sequence s_w4;
      burst_start && bus_config[3:0] == 4'h1 ##2 adv1;
   endsequence
   sequence s_cont;
      burst_start && bus_config[2:0] == BL_CONT ##2 adv1;
   endsequence
   // Register, array and response path
   a_reset_val: assert property ($rose(rst_b) |-> bus_config == BCR_RESET)
      else $error("bus config not at reset value");
   a_pin_write: assert property (tk && config_reg_select && op_req.write
      && op_req.addr[19:18] == PIN_SEL_BCR |=> bus_config == $past(op_req.wdata))
      else $error("pin write lost");
   a_pin_read: assert property (tk && config_reg_select && !op_req.write
      && op_req.addr[19:18] == PIN_SEL_BCR && !rsp_valid
      |=> rsp_valid && rsp_data == $past(bus_config)) else $error("pin read wrong");
   a_pin_noarr: assert property (tk && config_reg_select |=> !arr_valid)
      else $error("register op reached array");
   a_array_op: assert property (tk && !config_reg_select && op_req.addr != TOP_ADDR
      |=> arr_valid && arr_req == $past(op_req)) else $error("array op lost");
   a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
      else $error("held word changed");
   // Burst path
   a_start_addr: assert property (burst_start
      |=> burst_active && burst_addr == $past(burst_start_addr)) else $error("burst start");
   a_wrap_four: assert property (s_w4 |=> burst_addr[1:0] == $past(burst_addr[1:0]) + 2'h1
      && burst_addr[20:2] == $past(burst_addr[20:2])) else $error("wrap step wrong");
   a_cont_step: assert property (s_cont
      |=> burst_active && burst_addr == $past(burst_addr) + 21'h1) else $error("cont step");
   a_four_end: assert property (s_w4 ##2 adv1 ##2 adv1 ##2 adv1 |=> !burst_active)
      else $error("burst of four did not end");
   a_adv_idle: assert property (!burst_active && adv1 |=> !burst_active)
      else $error("idle advance started burst");
endmodule
bind pcab_core pcab_core_asserts u_pcab_core_asserts (.sys_clk, .rst_b, .config_reg_select,
   .op_valid, .op_ready, .op_req, .arr_valid, .arr_req, .rsp_valid, .rsp_ready, .rsp_data,
   .burst_start, .burst_start_addr, .burst_adv, .burst_stop, .burst_active, .burst_addr,
   .bus_config);

// ===== pcab_core_tb.sv
// Self-checking testbench of the config access and burst core
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
   $display("mismatch %s expected %h seen %h", n, e, g); end end
module pcab_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pcab_pkg::*;
   localparam logic [15:0] IDV = 16'h3C96; // Arbitrary identification value
   logic sys_clk = 0, rst_b = 0, config_reg_select = 0, op_valid = 0, rsp_ready = 1;
   logic burst_start = 0, burst_adv = 0, burst_stop = 0;
   logic arr_valid, arr_rvalid, op_ready, rsp_valid, burst_active;
   pcab_op_t op_req = '0;
   pcab_arr_t arr_req;
   logic [15:0] arr_rdata, rsp_data, bus_config, refresh_config, rd, d, d2, d3;
   logic [20:0] burst_start_addr = '0, burst_addr, a, s;
   logic [15:0] ex [4];
   logic [2:0] cd [5] = '{BL_4, BL_8, BL_16, BL_32, BL_CONT};
   int errors = 0, samples_checked = 0, seed = 32'h82cf98f3, nw;
   always #50 sys_clk = ~sys_clk;
   pcab_core #(.IDENT_VALUE(IDV)) u_pcab_core (.sys_clk, .rst_b, .config_reg_select,
      .op_valid, .op_ready, .op_req, .arr_valid, .arr_req, .arr_rvalid, .arr_rdata,
      .rsp_valid, .rsp_ready, .rsp_data, .burst_start, .burst_start_addr, .burst_adv,
      .burst_stop, .burst_active, .burst_addr, .bus_config, .refresh_config);
   pcab_mem u_pcab_mem (.sys_clk, .arr_valid, .arr_req, .arr_rvalid, .arr_rdata);
   // Verdict and end of run
   task automatic close_out(input bit to);
      if (to) errors++;
      $display("checked %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // One operation, held until taken
   task automatic op(input logic w, s, input logic [20:0] ad, input logic [15:0] dt);
      int n;
      n = 0;
      @(posedge sys_clk);
      op_valid <= 1'b1;
      config_reg_select <= s;
      op_req <= '{w, ad, dt};
      do begin @(posedge sys_clk); n++; end while (op_ready !== 1'b1 && n < 100);
      op_valid <= 1'b0;
      if (n >= 100) close_out(1);
   endtask
   // Collect one read word
   task automatic rsp(output logic [15:0] v);
      int n;
      n = 0;
      do begin @(posedge sys_clk); n++; end while (rsp_valid !== 1'b1 && n < 100);
      v = rsp_data;
      if (n >= 100) close_out(1);
   endtask
   // Software sequence at the top address
   task automatic sw(input logic w4, input logic [15:0] sl, dt);
      op(0, 0, TOP_ADDR, 0);
      rsp(rd);
      op(0, 0, TOP_ADDR, 0);
      rsp(rd);
      op(1, 0, TOP_ADDR, sl);
      op(w4, 0, TOP_ADDR, dt);
      if (!w4) rsp(rd);
   endtask
   // Burst control pulse
   task automatic pl(input logic [2:0] k);
      @(posedge sys_clk);
      {burst_start, burst_adv, burst_stop} <= k;
      @(posedge sys_clk);
      {burst_start, burst_adv, burst_stop} <= 3'b000;
      #1;
   endtask
   // Expected burst word address
   function automatic logic [20:0] ba(logic [2:0] c, logic w, logic [20:0] s, int k);
      logic [20:0] m;
      m = (21'h2 << c) - 21'h1;
      if (c == BL_CONT || w) return s + 21'(k);
      return (s & ~m) | ((s + 21'(k)) & m);
   endfunction
   // Main sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      #1 `CHK("bcr_rst", BCR_RESET, bus_config)
      d = 16'($random(seed));
      d2 = 16'($random(seed));
      sw(1, SW_SEL_BCR, d);
      #1 `CHK("sw_load", d, bus_config)
      `CHK("top_kept", TOP_ADDR[15:0] ^ 16'h5A5A, rd)
      sw(0, SW_SEL_RCR, 0);
      `CHK("sw_rd_rcr", RCR_RESET, rd)
      sw(1, SW_SEL_RCR, d2);
      #1 `CHK("rcr_load", d2, refresh_config)
      sw(0, SW_SEL_BCR, 0);
      `CHK("sw_rd_bcr", d, rd)
      sw(0, SW_SEL_DEVICE_IDENT_REG, 0);
      `CHK("sw_rd_id", IDV, rd)
      $display("test software sequence done");
      d3 = 16'($random(seed));
      op(1, 1, {1'b0, PIN_SEL_BCR, 18'h0_0000}, d3);
      op(1, 1, {1'b1, PIN_SEL_DEVICE_IDENT_REG, 18'h3_FFFF}, ~IDV);
      ex = '{d2, IDV, d3, ZERO_WORD};
      for (int i = 0; i < 4; i++) begin
         a = 21'($random(seed));
         a[19:18] = 2'(i);
         op(0, 1, a, 16'($random(seed)));
         rsp(rd);
         `CHK("pin_rd", ex[i], rd)
      end
      // Stall the receiver until the buffer refuses
      rsp_ready <= 1'b0;
      op(0, 1, {1'b0, PIN_SEL_BCR, 18'h0_0000}, 0);
      op(0, 1, {1'b0, PIN_SEL_BCR, 18'h0_0000}, 0);
      #1 `CHK("full", 1'b0, op_ready)
      @(posedge sys_clk);
      rsp_ready <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         rsp(rd);
         `CHK("drain", d3, rd)
      end
      $display("test pin access done");
      // Broken order falls back to idle
      op(0, 0, TOP_ADDR, 0);
      rsp(rd);
      op(0, 0, 21'h00_0100, 0);
      rsp(rd);
      op(1, 0, TOP_ADDR, SW_SEL_BCR);
      op(1, 0, TOP_ADDR, d2);
      #1 `CHK("no_load", d3, bus_config)
      op(0, 0, TOP_ADDR, 0);
      rsp(rd);
      `CHK("top_new", d2, rd)
      $display("test broken sequence done");
      for (int c = 0; c < 5; c++) begin
         for (int w = 0; w < 2; w++) begin
            op(1, 1, {1'b0, PIN_SEL_BCR, 18'h0_0000}, {12'h000, w[0], cd[c]});
            s = (cd[c] == BL_CONT) ? TOP_ADDR - 21'h2 : 21'($random(seed));
            burst_start_addr <= s;
            nw = (cd[c] == BL_CONT) ? 6 : (2 << cd[c]);
            pl(3'b100);
            for (int k = 0; k < nw; k++) begin
               `CHK("baddr", ba(cd[c], w[0], s, k), burst_addr)
               pl(3'b010);
            end
            `CHK("bact", 1'(cd[c] == BL_CONT), burst_active)
            pl(3'b001);
         end
      end
      pl(3'b010);
      `CHK("idle", 1'b0, burst_active)
      $display("test burst done");
      close_out(0);
   end
endmodule
